// >>> hw/timer3_params.svh
// register offsets, field positions, reset values and codes of the 16-bit timer/counter
// assumes a 32-bit bus with one register to an aligned word
`ifndef TIMER3_PARAMS_SVH
`define TIMER3_PARAMS_SVH

// byte addresses of the registers
`define CTRL_OFFSET 8'h00
`define COUNT_LOW_OFFSET 8'h04
`define COUNT_HIGH_OFFSET 8'h08
`define FLAGS_OFFSET 8'h0C
`define ENABLES_OFFSET 8'h10
`define PRIORITY_OFFSET 8'h14

// reset values
`define CTRL_RESET 8'h00
`define COUNT_RESET 16'h0000
`define BYTE_RESET 8'h00

// overflow bit position in the flag, enable and priority registers
`define OVF_BIT 1

// compare mode code that fires the special event trigger
`define SPECIAL_TRIGGER_MODE 4'hB

// last count before the wrap
`define COUNT_MAX 16'hFFFF

`endif

// >>> hw/timer3_pkg.sv
// types shared by the 16-bit timer/counter
// assumes timer3_params.svh holds every numeric constant
package timer3_pkg;

    // control register, bit 7 down to bit 0
    typedef struct packed {
        logic wide_access_mode;
        logic timebase_hi;
        logic [1:0] input_prescale_select;
        logic timebase_lo;
        logic external_sync_bypass;
        logic count_source_select;
        logic counter_run;
    } ctrl_t;

    // prescale ratios
    typedef enum logic [1:0] {
        PS_DIV1 = 2'h0,
        PS_DIV2 = 2'h1,
        PS_DIV4 = 2'h2,
        PS_DIV8 = 2'h3
    } prescale_t;

    // which timer each capture/compare unit is handed
    typedef struct packed {
        logic unit_one_uses_this;
        logic unit_two_uses_this;
    } timebase_t;

endpackage

// >>> hw/timer3_counter.sv
// 16-bit up timer/counter with prescaler, buffered wide access and trigger reset
// assumes an APB master on ref_clk (the instruction clock), async count pins,
// and capture/compare units that deliver one-cycle match pulses on ref_clk
//
// Contract
// - counter counts up through low and high byte, wrapping FFFF to 0000
// - each wrap latches overflow flag bit 1; interrupt only when enable bit set
// - source select 0 counts every instruction cycle, 1 counts external rising edges
// - external rising edge counts only after a falling edge since setup
// - sync bypass picks synchronized or unsynchronized external input; ignored internally
// - prescale field divides the source by 1, 2, 4 or 8
// - run bit lets the counter advance; cleared, the counter holds
// - time-base pair gives this counter to both, unit two, or neither
// - wide access bit selects one 16-bit access or two byte accesses
// - wide mode low-byte read copies live high byte into buffer; high reads return it
// - wide mode high writes go to buffer; loaded together with the low write
// - low-byte write clears the prescaler; high-byte write leaves it
// - special event trigger of a unit on this time base clears the counter
// - a unit two trigger also requests an A/D conversion when the converter is enabled
// - a counter write in the trigger cycle wins and the reset is dropped
// - a trigger reset from unit two never sets the overflow flag
// - secondary oscillator enabled forces its two pins to inputs reading zero
//
// Local design decisions: the APB slave port and the register offsets.
`include "timer3_params.svh"

module timer3_counter #(
    parameter int ADDR_WIDTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // apb slave
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external count pins
    input wire logic external_count_input,
    input wire logic secondary_osc_input,
    input wire logic secondary_osc_enable,
    // capture/compare units
    input wire logic [3:0] unit_one_mode,
    input wire logic unit_one_match,
    input wire logic [3:0] unit_two_mode,
    input wire logic unit_two_match,
    output timer3_pkg::timebase_t timebase,
    output logic [15:0] count_value,
    // converter
    input wire logic adc_enable,
    output logic adc_start_request,
    // interrupt line
    output logic overflow_irq,
    // shared port pins
    input wire logic [1:0] port_c_direction,
    input wire logic [1:0] port_c_pins,
    output logic [1:0] port_c_direction_eff,
    output logic [1:0] port_c_read
);
    import timer3_pkg::*;

    ctrl_t ctrl;
    logic [15:0] count;
    logic [7:0] high_buffer;
    logic [2:0] presc;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic overflow_irq_priority;
    logic [2:0] ext_sync;
    logic ext_level;
    logic ext_armed;
    logic ext_edge_q;
    wire logic [1:0] pin_level;

    // bus phases: capture the answer one cycle into access, act when it completes
    logic acc;
    logic cap;
    logic wr;
    logic wr_ctrl;
    logic wr_low;
    logic wr_high;
    logic wr_flags;
    logic rd_low_cap;
    assign acc = psel & penable & pready;
    assign cap = psel & penable & ~pready;
    assign wr = acc & pwrite;
    assign wr_ctrl = wr & (paddr == `CTRL_OFFSET);
    assign wr_low = wr & (paddr == `COUNT_LOW_OFFSET);
    assign wr_high = wr & (paddr == `COUNT_HIGH_OFFSET);
    assign wr_flags = wr & (paddr == `FLAGS_OFFSET);
    assign rd_low_cap = cap & ~pwrite & (paddr == `COUNT_LOW_OFFSET);

    // external source: oscillator pin when enabled, else the count pin
    logic ext_pin;
    logic ext_rise;
    logic ext_fall;
    logic ext_tick;
    logic src_tick;
    assign ext_pin = secondary_osc_enable ? secondary_osc_input : external_count_input;
    assign ext_rise = ext_sync[2] & ext_sync[1] & ~ext_level;
    assign ext_fall = ~ext_sync[2] & ~ext_sync[1] & ext_level;

    // three-stage synchronizer; level changes only once stages two and three agree
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ext_sync <= 3'h0;
            ext_level <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[1:0], ext_pin};
            if (ext_sync[1] == ext_sync[2]) begin
                ext_level <= ext_sync[2];
            end
        end
    end

    // arm on a falling edge; re-setup via the control register disarms
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ext_armed <= 1'b0;
        end else if (wr_ctrl) begin
            ext_armed <= 1'b0;
        end else if (ext_fall) begin
            ext_armed <= 1'b1;
        end
    end

    // synchronized path adds one register stage; bypass takes the edge at once
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ext_edge_q <= 1'b0;
        end else begin
            ext_edge_q <= ext_rise & ext_armed;
        end
    end

    assign ext_tick = ctrl.external_sync_bypass ? (ext_rise & ext_armed) : ext_edge_q;
    assign src_tick = ctrl.count_source_select ? ext_tick : 1'b1;

    // prescaler hit decode
    logic presc_hit;
    always_comb begin
        case (prescale_t'(ctrl.input_prescale_select))
            PS_DIV1: presc_hit = 1'b1;
            PS_DIV2: presc_hit = presc[0];
            PS_DIV4: presc_hit = &presc[1:0];
            PS_DIV8: presc_hit = &presc;
            default: presc_hit = 1'b1;
        endcase
    end

    logic advance;
    assign advance = ctrl.counter_run & src_tick & presc_hit;

    // prescaler only moves while running; low write restarts it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            presc <= 3'h0;
        end else if (wr_low) begin
            presc <= 3'h0;
        end else if (ctrl.counter_run && src_tick) begin
            presc <= presc + 3'h1;
        end
    end

    // trigger qualification: mode code and time-base ownership
    logic trig_one;
    logic trig_two;
    logic trig;
    logic cnt_wr;
    assign trig_one = unit_one_match & (unit_one_mode == `SPECIAL_TRIGGER_MODE)
        & ctrl.timebase_hi;
    assign trig_two = unit_two_match & (unit_two_mode == `SPECIAL_TRIGGER_MODE)
        & (ctrl.timebase_hi | ctrl.timebase_lo);
    assign trig = trig_one | trig_two;
    assign cnt_wr = wr_low | (wr_high & ~ctrl.wide_access_mode);

    // control register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= ctrl_t'(`CTRL_RESET);
        end else if (wr_ctrl) begin
            ctrl <= ctrl_t'(pwdata[7:0]);
        end
    end

    // counter: software write beats trigger beats counting
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count <= `COUNT_RESET;
        end else if (wr_low) begin
            count[7:0] <= pwdata[7:0];
            if (ctrl.wide_access_mode) begin
                count[15:8] <= high_buffer;
            end
        end else if (wr_high && !ctrl.wide_access_mode) begin
            count[15:8] <= pwdata[7:0];
        end else if (trig) begin
            count <= `COUNT_RESET;
        end else if (advance) begin
            count <= count + 16'h0001;
        end
    end

    // high-byte buffer for wide access; snapped with the low-byte read data
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            high_buffer <= `BYTE_RESET;
        end else if (ctrl.wide_access_mode && wr_high) begin
            high_buffer <= pwdata[7:0];
        end else if (ctrl.wide_access_mode && rd_low_cap) begin
            high_buffer <= count[15:8];
        end
    end

    // overflow flag: the set term is masked by trig, so a reset never sets it
    logic ovf_set;
    logic ovf_clr;
    assign ovf_set = advance & (count == `COUNT_MAX) & ~cnt_wr & ~trig;
    assign ovf_clr = wr_flags & ~pwdata[`OVF_BIT];
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            overflow_flag <= 1'b0;
        end else begin
            overflow_flag <= ovf_set | (overflow_flag & ~ovf_clr);
        end
    end

    // enable and priority bits
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            overflow_irq_enable <= 1'b0;
            overflow_irq_priority <= 1'b0;
        end else if (wr && paddr == `ENABLES_OFFSET) begin
            overflow_irq_enable <= pwdata[`OVF_BIT];
        end else if (wr && paddr == `PRIORITY_OFFSET) begin
            overflow_irq_priority <= pwdata[`OVF_BIT];
        end
    end

    // registered side outputs
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            overflow_irq <= 1'b0;
            adc_start_request <= 1'b0;
            timebase <= '0;
        end else begin
            overflow_irq <= overflow_flag & overflow_irq_enable;
            adc_start_request <= trig_two & adc_enable;
            timebase.unit_one_uses_this <= ctrl.timebase_hi;
            timebase.unit_two_uses_this <= ctrl.timebase_hi | ctrl.timebase_lo;
        end
    end

    assign count_value = count;

    // read mux, captured one cycle before completion so pready and data rise together
    logic [7:0] rd_byte;
    logic rd_hit;
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (paddr)
            `CTRL_OFFSET: rd_byte = ctrl;
            `COUNT_LOW_OFFSET: rd_byte = count[7:0];
            `COUNT_HIGH_OFFSET: rd_byte = ctrl.wide_access_mode ? high_buffer : count[15:8];
            `FLAGS_OFFSET: rd_byte = {6'h00, overflow_flag, 1'b0};
            `ENABLES_OFFSET: rd_byte = {6'h00, overflow_irq_enable, 1'b0};
            `PRIORITY_OFFSET: rd_byte = {6'h00, overflow_irq_priority, 1'b0};
            default: rd_hit = 1'b0;
        endcase
    end

    // apb answer: one wait cycle, unmapped gives pslverr and zero data
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= cap;
            if (cap) begin
                prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
                pslverr <= ~rd_hit;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // shared pins: synchronized, overridden while the oscillator owns them
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            logic [2:0] pin_sync;
            logic pin_lvl;
            // one filtered level per pin, so no vector is written by two processes
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    pin_sync <= 3'h0;
                    pin_lvl <= 1'b0;
                end else begin
                    pin_sync <= {pin_sync[1:0], port_c_pins[gi]};
                    if (pin_sync[1] == pin_sync[2]) begin
                        pin_lvl <= pin_sync[2];
                    end
                end
            end
            assign pin_level[gi] = pin_lvl;
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            port_c_direction_eff <= 2'h3;
            port_c_read <= 2'h0;
        end else begin
            port_c_direction_eff <= secondary_osc_enable ? 2'h3 : port_c_direction;
            port_c_read <= secondary_osc_enable ? 2'h0 : pin_level;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_wide_high_write;
        ctrl.wide_access_mode && wr_high;
    endsequence

    sequence s_plain_advance;
        advance && !cnt_wr && !trig;
    endsequence

    a_count_wrap: assert property (
        s_plain_advance and (count == `COUNT_MAX) |=> (count == 16'h0000) && overflow_flag)
        else $error("counter did not wrap to zero with overflow");
    a_count_step: assert property (
        s_plain_advance and (count != `COUNT_MAX) |=> count == $past(count) + 16'h0001)
        else $error("counter did not step by one");
    a_irq_gate: assert property (
        overflow_flag && overflow_irq_enable |=> overflow_irq)
        else $error("interrupt not raised for enabled overflow");
    a_flag_sticky: assert property (
        overflow_flag && !ovf_clr |=> overflow_flag)
        else $error("overflow flag dropped without a clear");
    a_halt_hold: assert property (
        !ctrl.counter_run && !cnt_wr && !trig |=> $stable(count))
        else $error("halted counter moved");
    a_presc_clear: assert property (
        wr_low |=> presc == 3'h0)
        else $error("low write left prescaler");
    a_wide_buffer: assert property (
        s_wide_high_write |=> high_buffer == $past(pwdata[7:0]))
        else $error("wide high write did not land in the buffer");
    a_wide_pair: assert property (
        ctrl.wide_access_mode && wr_low |=> count[15:8] == $past(high_buffer))
        else $error("buffered high byte not loaded with low write");
    a_trigger_reset: assert property (
        trig && !cnt_wr |=> count == 16'h0000)
        else $error("trigger did not clear counter");
    a_write_wins: assert property (
        trig && wr_low |=> count[7:0] == $past(pwdata[7:0]))
        else $error("trigger overrode counter write");
    a_trig_no_flag: assert property (
        trig_two && !overflow_flag |=> !overflow_flag)
        else $error("unit two trigger set overflow flag");
    a_adc_request: assert property (
        trig_two && adc_enable |=> adc_start_request)
        else $error("trigger gave no conversion request");
    a_arm_first: assert property (
        ctrl.count_source_select && ctrl.external_sync_bypass && ext_rise && !ext_armed
        && !cnt_wr && !trig |=> $stable(count))
        else $error("edge counted before any falling edge");
endmodule

// >>> test/timer3_partner.sv
// compare units and count pins on the far side of the timer
// assumes the bench calls one task at a time, pins idle low between bursts
`include "timer3_params.svh"
module timer3_partner (
    // clock
    input wire logic ref_clk,
    // count pins
    output logic external_count_input,
    output logic secondary_osc_input,
    // compare units
    output logic [3:0] unit_one_mode,
    output logic unit_one_match,
    output logic [3:0] unit_two_mode,
    output logic unit_two_match
);
    timeunit 1ns;
    timeprecision 1ns;

    // unit one compares without trigger, so it must never clear the count
    initial begin
        external_count_input = 1'b0;
        secondary_osc_input = 1'b0;
        unit_one_mode = 4'hA;
        unit_two_mode = `SPECIAL_TRIGGER_MODE;
        unit_one_match = 1'b0;
        unit_two_match = 1'b0;
    end

    // each level held four cycles, above the two-cycle pin filter
    task automatic edges(input int k, input logic osc);
        repeat (k) begin
            for (int lvl = 1; lvl >= 0; lvl--) begin
                @(posedge ref_clk);
                if (osc)
                    secondary_osc_input <= lvl[0];
                else
                    external_count_input <= lvl[0];
                repeat (3) @(posedge ref_clk);
            end
        end
    endtask

    // one-cycle match pulse, as a real compare unit gives
    task automatic fire(input logic two);
        @(posedge ref_clk);
        if (two)
            unit_two_match <= 1'b1;
        else
            unit_one_match <= 1'b1;
        @(posedge ref_clk);
        unit_two_match <= 1'b0;
        unit_one_match <= 1'b0;
    endtask
endmodule

// >>> test/tb_sixteen_bit_timer_counter_three.sv
// self-checking bench for the 16-bit timer/counter over apb
// assumes timer3_partner drives count pins and compare units
`include "timer3_params.svh"
module tb_sixteen_bit_timer_counter_three;
    timeunit 1ns;
    timeprecision 1ns;
    import timer3_pkg::*;

    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ext_in, osc_in, match_one, match_two;
    logic osc_en = 1'b0;
    logic [3:0] mode_one, mode_two;
    timebase_t timebase;
    logic [15:0] count_value;
    logic adc_enable = 1'b1;
    logic adc_start_request, overflow_irq;
    logic [1:0] dir = 2'h0;
    logic [1:0] pins = 2'h0;
    logic [1:0] dir_eff, pin_read;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [15:0] seed = 16'hC506;

    timer3_counter u_timer3_counter (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_count_input(ext_in),
        .secondary_osc_input(osc_in), .secondary_osc_enable(osc_en), .unit_one_mode(mode_one),
        .unit_one_match(match_one), .unit_two_mode(mode_two), .unit_two_match(match_two),
        .timebase(timebase), .count_value(count_value), .adc_enable(adc_enable),
        .adc_start_request(adc_start_request), .overflow_irq(overflow_irq),
        .port_c_direction(dir), .port_c_pins(pins), .port_c_direction_eff(dir_eff),
        .port_c_read(pin_read));

    timer3_partner u_timer3_partner (.ref_clk(ref_clk), .external_count_input(ext_in),
        .secondary_osc_input(osc_in), .unit_one_mode(mode_one), .unit_one_match(match_one),
        .unit_two_mode(mode_two), .unit_two_match(match_two));

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // 16-bit lfsr for random stimulus
    function logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk(e, err);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    initial begin
        logic [15:0] c0, v;
        int k;
        tick(5);
        resetn <= 1'b1;
        // reset values, then an unmapped offset that must be refused
        for (int a = 0; a < 6; a++) rd(8'(a * 4), 32'h0, 1'b0);
        rd(8'h18, 32'h0, 1'b1);
        // every prescale code over 32 cycles of the internal source
        for (int p = 0; p < 4; p++) begin
            wr(`CTRL_OFFSET, 32'(p * 16 + 1));
            tick(4);
            c0 = count_value;
            tick(32);
            chk(16'(count_value - c0), 32 >> p);
        end
        wr(`CTRL_OFFSET, 32'h0);
        tick(2);
        c0 = count_value;
        tick(16);
        chk(count_value, c0);
        // byte mode: independent halves
        v = rnd();
        wr(`COUNT_HIGH_OFFSET, v[15:8]);
        wr(`COUNT_LOW_OFFSET, v[7:0]);
        tick(1);
        chk(count_value, v);
        rd(`COUNT_LOW_OFFSET, v[7:0], 1'b0);
        rd(`COUNT_HIGH_OFFSET, v[15:8], 1'b0);
        // wrap with the interrupt masked, then unmasked, cleared and set again
        wr(`ENABLES_OFFSET, 32'h0);
        wr(`COUNT_HIGH_OFFSET, 8'hFF);
        wr(`COUNT_LOW_OFFSET, 8'hFE);
        wr(`CTRL_OFFSET, 32'h1);
        tick(6);
        chk(count_value[15:8], 8'h00);
        rd(`FLAGS_OFFSET, 32'h2, 1'b0);
        chk(overflow_irq, 1'b0);
        wr(`ENABLES_OFFSET, 32'h2);
        tick(2);
        chk(overflow_irq, 1'b1);
        wr(`FLAGS_OFFSET, 32'h0);
        rd(`FLAGS_OFFSET, 32'h0, 1'b0);
        wr(`COUNT_HIGH_OFFSET, 8'hFF);
        wr(`COUNT_LOW_OFFSET, 8'hFF);
        tick(3);
        rd(`FLAGS_OFFSET, 32'h2, 1'b0);
        // every time-base pair; the first write also stops the counter
        for (int i = 0; i < 4; i++) begin
            wr(`CTRL_OFFSET, 32'(i[1] * 64 + i[0] * 8));
            tick(2);
            chk(timebase, {i[1], i[1] | i[0]});
        end
        // wide mode: high write waits in the buffer until the low write
        wr(`CTRL_OFFSET, 8'h80);
        c0 = count_value;
        wr(`COUNT_HIGH_OFFSET, 8'h12);
        tick(1);
        chk(count_value, c0);
        wr(`COUNT_LOW_OFFSET, 8'h34);
        tick(1);
        chk(count_value, 16'h1234);
        rd(`COUNT_LOW_OFFSET, 8'h34, 1'b0);
        wr(`FLAGS_OFFSET, 32'h0);
        // timer mode with unit two on this time base so that the trigger reset is honoured
        wr(`CTRL_OFFSET, 8'h89);
        // second trigger with the converter off must give no request
        for (int j = 0; j < 2; j++) begin
            adc_enable <= (j == 0);
            u_timer3_partner.fire(1'b1);
            k = 0;
            repeat (4) begin
                @(posedge ref_clk);
                if (adc_start_request === 1'b1) k++;
            end
            chk(k, (j == 0) ? 1 : 0);
            chk(count_value[15:4], 12'h000);
        end
        rd(`COUNT_HIGH_OFFSET, 8'h12, 1'b0);
        rd(`FLAGS_OFFSET, 32'h0, 1'b0);
        // external pin synced, bypassed, then the secondary oscillator
        for (int s = 0; s < 3; s++) begin
            osc_en <= (s == 2);
            tick(4);
            wr(`CTRL_OFFSET, (s == 1) ? 8'h07 : 8'h03);
            tick(2);
            c0 = count_value;
            k = 2 + rnd() % 8;
            // the pin starts low, so the first rise is not yet armed
            u_timer3_partner.edges(k, s == 2);
            tick(6);
            chk(16'(count_value - c0), k - 1);
            if (s == 2) begin
                chk(dir_eff, 2'h3);
                chk(pin_read, 2'h0);
            end
        end
        osc_en <= 1'b0;
        dir <= 2'h1;
        pins <= 2'h2;
        tick(6);
        chk(dir_eff, 2'h1);
        chk(pin_read, 2'h2);
        end_of_test();
    end
endmodule
